// *** cam_housekeeping_command_unit_bench.sv ***
// Purpose: self-checking bench of the cam housekeeping command unit
// Assumes: host accesses held 6 clocks, 5 idle clocks between them
// Notes:   completion is found by polling the busy register
`timescale 1ns/1ps
`default_nettype none
module cam_housekeeping_command_unit_bench;
    import chk_pkg::*;
    logic         clk = 1'b0, rst = 1'b1, slow = 1'b0;
    logic         sharedSelN = 1'b1, privateSelN = 1'b1, writeN = 1'b1;
    logic [7:0]   addr = 8'h00;
    logic [15:0]  dataIn = 16'h0000, dataOut, rd, v, a, p;
    logic         stampAdvanceInput = 1'b0, camFullN = 1'b1;
    logic         dataOeN, interruptOutN, camValid, camAck, oe;
    logic [7:0]   currentStamp, cur = 8'h00, pur = 8'h00;
    logic [3:0]   portDaEnable, portSaEnable;
    chk_cam_cmd_t camCmd, lastCmd;
    chk_cam_rsp_t camRsp;
    logic [31:0]  seed = 32'hb642;
    int           n_fail = 0, n_tests = 0, nAck = 0, n, k;
    localparam logic [7:0] ROFS [9] = '{8'h03, 8'h05, 8'h06, 8'h07, 8'h08, 8'h10, 8'h11, 8'h20, 8'h30};

    chk_cmd_unit dut (.clk, .rst, .sharedSelN, .privateSelN, .writeN, .addr, .dataIn, .dataOut, .dataOeN,
        .stampAdvanceInput, .camFullN, .interruptOutN, .camValid, .camCmd, .camAck, .camRsp,
        .currentStamp, .portDaEnable, .portSaEnable);
    chk_cam_model cam (.clk, .rst, .slow, .camValid, .camCmd, .camAck, .camRsp, .lastCmd);

    always #4 clk = ~clk;
    always @(posedge clk) if (camAck === 1'b1) nAck <= nAck + 1;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [15:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[15:0];
    endfunction
    function automatic logic [15:0] sw(input logic [15:0] w);
        return {w[7:0], w[15:8]};
    endfunction
    task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic acc(input logic pv, input logic w, input logic [7:0] ad, input logic [15:0] d);
        {sharedSelN, privateSelN, writeN, addr, dataIn} <= {pv, !pv, !w, ad, d};
        repeat (5) @(posedge clk);
        #1 rd = dataOut;
        oe = dataOeN;
        @(posedge clk);
        {sharedSelN, privateSelN, writeN} <= 3'b111;
        repeat (5) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [15:0] d);
        acc(1'b0, 1'b1, ad, d);
        chk(oe, 1'b1);
    endtask
    task automatic rdc(input logic [7:0] ad, input logic [15:0] exp);
        acc(1'b0, 1'b0, ad, rnd());
        chk({oe, rd}, {1'b0, exp});
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 200; i++) begin
            acc(1'b0, 1'b0, OFS_BUSY, 16'h0000);
            if (rd[0] === 1'b0) return;
        end
        n_fail++;
        close_out();
    endtask
    task automatic stamps();
        chk(currentStamp, cur);
        rdc(OFS_CUR_STAMP, {8'h00, cur});
        rdc(OFS_PUR_STAMP, {8'h00, pur});
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (ROFS[i]) rdc(ROFS[i], 16'h0000);
        $display("reset values done");
        foreach (ROFS[i]) if (i < 5) begin
            v = rnd();
            wr(ROFS[i], v);
            rdc(ROFS[i], v);
        end
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, 1'b1, PORT_OFS[i], 16'h0060);
            chk({portDaEnable[i], portSaEnable[i]}, 2'b11);
        end
        $display("registers done");
        wr(OFS_STAGE_3, 16'h6002);
        wr(OFS_STAGE_2, 16'h128c);
        wr(OFS_STAGE_1, 16'h5634);
        v = 16'h8000 | (rnd() & 16'h3f00);
        wr(OFS_STAGE_0, v);
        wr(CMD_OFS[C_ADD], rnd());
        wait_idle();
        chk({lastCmd.op, lastCmd.key, lastCmd.data}, {CO_ADD, 48'h02608c123456, v});
        wr(OFS_STAGE_2, 16'h6002);
        wr(OFS_STAGE_1, 16'h128c);
        wr(OFS_STAGE_0, 16'h5634);
        wr(CMD_OFS[C_DEL], rnd());
        wait_idle();
        chk({lastCmd.op, lastCmd.key}, {CO_DELETE, 48'h02608c123456});
        $display("add and delete done");
        a = rnd();
        p = rnd() & 16'h0003;
        wr(OFS_STAGE_0, a);
        wr(CMD_OFS[C_SETADD], rnd());
        wait_idle();
        chk({lastCmd.op, lastCmd.data}, {CO_SETADDR, a});
        wr(OFS_STAGE_0, p);
        wr(CMD_OFS[C_READ], rnd());
        wait_idle();
        chk({lastCmd.op, lastCmd.data}, {CO_READ, p});
        rdc(OFS_STAGE_3, sw(a));
        rdc(OFS_STAGE_2, sw(~a));
        rdc(OFS_STAGE_1, sw(a ^ 16'h5a5a));
        rdc(OFS_STAGE_0, p);
        rdc(OFS_STAT_HIGH, 16'h3000);
        rdc(OFS_STAT_LOW, a);
        $display("read entry done");
        for (int i = 0; i < 8; i++) begin
            k = (i < 3) ? i : rnd() % 3;
            n = nAck;
            wr(CMD_OFS[C_INCTS + k], rnd());
            wait_idle();
            cur += (k != 1);
            pur += (k != 0);
            stamps();
            chk(nAck - n, k != 0);
            if (k != 0) chk({lastCmd.op, lastCmd.data, lastCmd.mask}, {CO_PURGE, 8'h00, pur, 16'h80ff});
        end
        $display("stamps done");
        slow <= 1'b1;
        n = nAck;
        wr(CMD_OFS[C_INCPR], rnd());
        wr(CMD_OFS[C_INCTS], rnd());
        wr(CMD_OFS[C_DEL], rnd());
        wait_idle();
        cur++;
        pur++;
        stamps();
        chk(nAck - n, 2);
        chk(lastCmd.op, CO_DELETE);
        slow <= 1'b0;
        $display("held triggers done");
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 16'h000e : (i == 1) ? 16'h0002 : (i == 2) ? 16'h0004 : 16'h0000;
            wr(OFS_SYS_TARGET, v);
            n = nAck;
            stampAdvanceInput <= 1'b1;
            repeat (6) @(posedge clk);
            stampAdvanceInput <= 1'b0;
            repeat (6) @(posedge clk);
            wait_idle();
            cur += v[1];
            pur += v[2];
            stamps();
            chk(nAck - n, v[2]);
            camFullN <= 1'b0;
            repeat (8) @(posedge clk);
            chk(interruptOutN, !v[3]);
            camFullN <= 1'b1;
        end
        $display("advance input done");
        close_out();
    end
endmodule
`default_nettype wire

// *** chk_cam_model.sv ***
// Purpose: behavioural cam chain answering routine commands
// Assumes: one command outstanding, ack is a one-cycle pulse
// Notes:   slow adds a long wait so that later triggers pile up
`timescale 1ns/1ps
`default_nettype none
module chk_cam_model
    import chk_pkg::*;
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // pacing
    input  wire logic         slow,
    // cam chain
    input  wire logic         camValid,
    input  wire chk_cam_cmd_t camCmd,
    output logic              camAck,
    output chk_cam_rsp_t      camRsp,
    output chk_cam_cmd_t      lastCmd
);
    logic [15:0] addrQ;
    logic [5:0]  waitQ;
    wire         goNow = camValid && !camAck && waitQ == (slow ? 6'd40 : 6'd0);

    always_ff @(posedge clk) begin
        if (rst) begin
            camAck  <= 1'b0;
            waitQ   <= 6'd0;
            addrQ   <= 16'h0000;
            camRsp  <= '0;
            lastCmd <= '0;
        end else begin
            camAck <= goNow;
            // idle response lines toggle so nothing stale passes as an answer
            camRsp <= ~camRsp;
            waitQ  <= (camValid && !camAck && !goNow) ? waitQ + 6'd1 : 6'd0;
            if (goNow) begin
                lastCmd <= camCmd;
                camRsp  <= {addrQ, ~addrQ, addrQ ^ 16'h5a5a, camCmd.data, 16'h3000, addrQ};
                if (camCmd.op == CO_SETADDR) addrQ <= camCmd.data;
            end
        end
    end
endmodule
`default_nettype wire

// *** chk_cmd_unit.sv ***
// Purpose: host command unit driving built-in routines on an external cam chain
// Assumes: host pins are asynchronous; cam chain runs on clk
// Notes:   one routine at a time, later triggers wait as pending bits
//
// Behaviour
// - any write to a command register starts it
// - delete looks up staged mac, deletes it
// - add writes staged mac and data
// - read uses word 0 as page, returns entry
// - offset 26 bumps current stamp
// - offset 27 bumps purge stamp, then purges
// - offset 28 bumps both, then purges
// - set-address sends word 0 as cam address
// - read returns entry at previously set address
// - purge never deletes permanent entries
// - page address selects one chain device
// - system target steers advance input, full interrupt
// - port target enables da, sa lookups
// - current stamp feeds source lookup bits 7-0
// - read copies status into two words
`timescale 1ns/1ps
`default_nettype none
module chk_cmd_unit
    import chk_pkg::*;
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // host register port
    input  wire logic         sharedSelN,
    input  wire logic         privateSelN,
    input  wire logic         writeN,
    input  wire logic [7:0]   addr,
    input  wire logic [15:0]  dataIn,
    output logic      [15:0]  dataOut,
    output logic              dataOeN,
    // system pins
    input  wire logic         stampAdvanceInput,
    input  wire logic         camFullN,
    output logic              interruptOutN,
    // cam chain
    output logic              camValid,
    output chk_cam_cmd_t      camCmd,
    input  wire logic         camAck,
    input  wire chk_cam_rsp_t camRsp,
    // to address lookup logic
    output logic      [7:0]   currentStamp,
    output logic      [3:0]   portDaEnable,
    output logic      [3:0]   portSaEnable
);
    // ****************************************************************
    // pin synchronisation
    // ****************************************************************
    logic        sShrN, sPrvN, sWrN, sAdv, sFullN;
    logic [7:0]  sAddr;
    logic [15:0] sData;

    chk_sync #(.W(29)) uSync (
        .clk    (clk),
        .rst    (rst),
        .async  ({sharedSelN, privateSelN, writeN, stampAdvanceInput, camFullN, addr, dataIn}),
        .synced ({sShrN, sPrvN, sWrN, sAdv, sFullN, sAddr, sData})
    );

    logic shrWr_q, prvWr_q, adv_q;
    wire  shrWrNow = ~sShrN & ~sWrN;
    wire  prvWrNow = ~sPrvN & ~sWrN;
    wire  sysWr    = shrWrNow & ~shrWr_q;
    wire  portWr   = prvWrNow & ~prvWr_q;
    wire  rdNow    = (~sShrN | ~sPrvN) & sWrN;

    always_ff @(posedge clk) begin
        if (rst) begin
            shrWr_q <= 1'b0;
            prvWr_q <= 1'b0;
            adv_q   <= 1'b1; // synced pin reads high in reset, no false edge after it
        end else begin
            shrWr_q <= shrWrNow;
            prvWr_q <= prvWrNow;
            adv_q   <= sAdv;
        end
    end

    // ****************************************************************
    // configuration and staging registers
    // ****************************************************************
    logic [15:0]      sysTarget_q;
    logic [3:0][15:0] word_q;
    logic [3:0][15:0] portCfg_q;
    logic [15:0]      statHi_q, statLo_q;
    chk_state_t       state_q;
    logic [2:0]       curOp_q;
    wire              readDone = (state_q == ST_CAM) & camAck & (curOp_q == 3'(C_READ));

    always_ff @(posedge clk) begin
        if (rst) begin
            sysTarget_q <= RST_WORD;
        end else if (sysWr & (sAddr == OFS_SYS_TARGET)) begin
            sysTarget_q <= sData;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : gWord
            wire hostHit = sysWr & (sAddr == OFS_STAGE_0 + 8'(gi));
            // mac words come back byte-swapped, the associated data word does not
            wire [15:0] seg = camRsp.entry[16*gi +: 16];
            wire [15:0] back = (gi == 0) ? seg : {seg[7:0], seg[15:8]};
            always_ff @(posedge clk) begin
                if (rst) begin
                    word_q[gi] <= RST_WORD;
                end else if (readDone) begin
                    word_q[gi] <= back;
                end else if (hostHit) begin
                    word_q[gi] <= sData;
                end
            end
        end
        for (gi = 0; gi < 4; gi++) begin : gPort
            always_ff @(posedge clk) begin
                if (rst) begin
                    portCfg_q[gi] <= RST_WORD;
                end else if (portWr & (sAddr == PORT_OFS[gi])) begin
                    portCfg_q[gi] <= sData;
                end
            end
            assign portDaEnable[gi] = portCfg_q[gi][PT_DA_BIT];
            assign portSaEnable[gi] = portCfg_q[gi][PT_SA_BIT];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            statHi_q <= RST_WORD;
            statLo_q <= RST_WORD;
        end else if (readDone) begin
            statHi_q <= camRsp.status[31:16];
            statLo_q <= camRsp.status[15:0];
        end
    end

    // ****************************************************************
    // command triggers and pending requests
    // ****************************************************************
    logic [NCMD-1:0] pend_q, hit, pick;
    generate
        for (gi = 0; gi < NCMD - 1; gi++) begin : gHit
            assign hit[gi] = sysWr & (sAddr == CMD_OFS[gi]);
        end
    endgenerate
    // external advance does nothing unless the system target enables it
    assign hit[C_EXT] = sAdv & ~adv_q
                      & (sysTarget_q[STG_ADV_CUR_BIT] | sysTarget_q[STG_ADV_PUR_BIT]);

    wire idle = (state_q == ST_IDLE);
    assign pick = idle ? (pend_q & (~pend_q + NCMD'(1))) : '0;

    always_ff @(posedge clk) begin
        if (rst) begin
            pend_q <= '0;
        end else begin
            pend_q <= (pend_q & ~pick) | hit;
        end
    end

    logic [2:0] pickIdx;
    always_comb begin
        pickIdx = 3'd0;
        for (int i = NCMD - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                pickIdx = 3'(i);
            end
        end
    end

    // ****************************************************************
    // time stamp counters
    // ****************************************************************
    logic [7:0] purgeStamp;
    wire  inBump = (state_q == ST_BUMP);
    wire  extCur = (curOp_q == 3'(C_EXT)) & sysTarget_q[STG_ADV_CUR_BIT];
    wire  extPur = (curOp_q == 3'(C_EXT)) & sysTarget_q[STG_ADV_PUR_BIT];
    wire  incCur = inBump & ((curOp_q == 3'(C_INCTS)) | (curOp_q == 3'(C_BOTH)) | extCur);
    wire  incPur = inBump & ((curOp_q == 3'(C_INCPR)) | (curOp_q == 3'(C_BOTH)) | extPur);
    wire  needCam = incPur | (curOp_q == 3'(C_DEL)) | (curOp_q == 3'(C_ADD))
                  | (curOp_q == 3'(C_READ)) | (curOp_q == 3'(C_SETADD));

    chk_stamp uCur (
        .clk   (clk),
        .rst   (rst),
        .inc   (incCur),
        .value (currentStamp)
    );

    chk_stamp uPur (
        .clk   (clk),
        .rst   (rst),
        .inc   (incPur),
        .value (purgeStamp)
    );

    // ****************************************************************
    // cam command build
    // ****************************************************************
    function automatic logic [15:0] swapB(input logic [15:0] w);
        swapB = {w[7:0], w[15:8]};
    endfunction

    wire [47:0] addKey = {swapB(word_q[3]), swapB(word_q[2]), swapB(word_q[1])};
    wire [47:0] delKey = {swapB(word_q[2]), swapB(word_q[1]), swapB(word_q[0])};
    chk_cam_cmd_t cmd_d;

    always_comb begin
        cmd_d = '{op: CO_PURGE, key: '0, data: RST_WORD, mask: FULL_MASK};
        case (curOp_q)
            3'(C_DEL): begin
                cmd_d.op  = CO_DELETE;
                cmd_d.key = delKey;
            end
            3'(C_ADD): begin
                cmd_d.op   = CO_ADD;
                cmd_d.key  = addKey;
                cmd_d.data = word_q[0];
            end
            3'(C_READ): begin
                cmd_d.op   = CO_READ;
                cmd_d.data = word_q[0];
            end
            3'(C_SETADD): begin
                cmd_d.op   = CO_SETADDR;
                cmd_d.data = word_q[0];
            end
            default: begin
                // permanent flag must read zero to match, so permanent entries survive
                cmd_d.data = {8'h00, purgeStamp + 8'h01};
                cmd_d.mask = PURGE_MASK;
            end
        endcase
    end

    // ****************************************************************
    // routine sequencer
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            curOp_q <= 3'd0;
            camCmd  <= '{op: CO_DELETE, key: '0, data: RST_WORD, mask: FULL_MASK};
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (|pend_q) begin
                        curOp_q <= pickIdx;
                        state_q <= ST_BUMP;
                    end
                end
                ST_BUMP: begin
                    camCmd  <= cmd_d;
                    state_q <= needCam ? ST_CAM : ST_IDLE;
                end
                ST_CAM: begin
                    if (camAck) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign camValid = (state_q == ST_CAM);

    // ****************************************************************
    // readback and interrupt
    // ****************************************************************
    logic [15:0] rdMux;
    logic        rdAct_q, fullIrq_q;
    always_comb begin
        rdMux = RST_WORD;
        if (~sPrvN) begin
            for (int i = 0; i < 4; i++) begin
                if (sAddr == PORT_OFS[i]) rdMux = portCfg_q[i];
            end
        end else begin
            case (sAddr)
                OFS_SYS_TARGET: rdMux = sysTarget_q;
                OFS_STAGE_0:    rdMux = word_q[0];
                OFS_STAGE_1:    rdMux = word_q[1];
                OFS_STAGE_2:    rdMux = word_q[2];
                OFS_STAGE_3:    rdMux = word_q[3];
                OFS_STAT_HIGH:  rdMux = statHi_q;
                OFS_STAT_LOW:   rdMux = statLo_q;
                OFS_CUR_STAMP:  rdMux = {8'h00, currentStamp};
                OFS_PUR_STAMP:  rdMux = {8'h00, purgeStamp};
                OFS_BUSY:       rdMux = {15'h0000, ~idle | (|pend_q)};
                default:        rdMux = RST_WORD;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dataOut   <= RST_WORD;
            rdAct_q   <= 1'b0;
            fullIrq_q <= 1'b0;
        end else begin
            dataOut   <= rdMux;
            rdAct_q   <= rdNow;
            fullIrq_q <= ~sFullN & sysTarget_q[STG_FULL_IRQ_BIT];
        end
    end

    assign dataOeN       = ~rdAct_q;
    assign interruptOutN = ~fullIrq_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    trigger_pend_a: assert property (hit[C_DEL] |=> pend_q[C_DEL] || state_q == ST_BUMP)
        else $error("delete trigger lost");
    one_routine_a: assert property (camValid && !camAck |=> camValid && $stable(camCmd))
        else $error("cam command changed while running");
    add_key_a: assert property (inBump && curOp_q == 3'(C_ADD) |=> camCmd.key == $past(addKey)
                                && camCmd.op == CO_ADD)
        else $error("add key wrong");
    del_key_a: assert property (inBump && curOp_q == 3'(C_DEL) |=> camCmd.key == $past(delKey)
                                && camCmd.op == CO_DELETE)
        else $error("delete key wrong");
    cur_bump_a: assert property (inBump && curOp_q == 3'(C_INCTS) |=> currentStamp == $past(currentStamp) + 8'h01
                                 && !camValid)
        else $error("current stamp not bumped");
    purge_bump_a: assert property (inBump && curOp_q == 3'(C_BOTH) |=> purgeStamp == $past(purgeStamp) + 8'h01
                                   && currentStamp == $past(currentStamp) + 8'h01
                                   && camValid && camCmd.data[7:0] == purgeStamp)
        else $error("purge not issued with new stamp");
    perm_keep_a: assert property (camValid && camCmd.op == CO_PURGE |-> camCmd.mask[PERM_BIT]
                                  && !camCmd.data[PERM_BIT])
        else $error("purge could hit permanent entry");
    read_status_a: assert property (readDone |=> statHi_q == $past(camRsp.status[31:16])
                                    && statLo_q == $past(camRsp.status[15:0]))
        else $error("status words not captured");
    full_irq_a: assert property (sysTarget_q[STG_FULL_IRQ_BIT] && !sFullN ##1 sysTarget_q[STG_FULL_IRQ_BIT]
                                 |-> !interruptOutN)
        else $error("full flag did not interrupt");

    add_run_c: cover property (inBump && curOp_q == 3'(C_ADD) ##1 camValid [*2] ##1 !camValid);
    read_run_c: cover property (readDone);
    held_trig_c: cover property (camValid && |hit);
    ext_purge_c: cover property (inBump && extPur);
endmodule
`default_nettype wire

// *** chk_pkg.sv ***
// Purpose: shared constants and types of the cam housekeeping command unit
// Assumes: 16-bit host register port, 8-bit register offsets
// Notes:   offsets are word offsets as seen on the host address pins
package chk_pkg;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] OFS_SYS_TARGET = 8'h03;
    localparam logic [7:0] OFS_STAGE_0    = 8'h05;
    localparam logic [7:0] OFS_STAGE_1    = 8'h06;
    localparam logic [7:0] OFS_STAGE_2    = 8'h07;
    localparam logic [7:0] OFS_STAGE_3    = 8'h08;
    localparam logic [7:0] OFS_STAT_HIGH  = 8'h0d;
    localparam logic [7:0] OFS_STAT_LOW   = 8'h0e;
    localparam logic [7:0] OFS_CUR_STAMP  = 8'h10;
    localparam logic [7:0] OFS_PUR_STAMP  = 8'h11;
    localparam logic [7:0] OFS_BUSY       = 8'h12;

    // command index order is also the service priority, lowest first
    localparam int NCMD = 8;
    localparam int C_DEL = 0;
    localparam int C_ADD = 1;
    localparam int C_READ = 2;
    localparam int C_INCTS = 3;
    localparam int C_INCPR = 4;
    localparam int C_BOTH = 5;
    localparam int C_SETADD = 6;
    localparam int C_EXT = 7;
    localparam logic [6:0][7:0] CMD_OFS = {8'h29, 8'h28, 8'h27, 8'h26, 8'h24, 8'h21, 8'h20};
    localparam logic [3:0][7:0] PORT_OFS = {8'h5a, 8'h52, 8'h4a, 8'h42};

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int STG_ADV_CUR_BIT = 1;
    localparam int STG_ADV_PUR_BIT = 2;
    localparam int STG_FULL_IRQ_BIT = 3;
    localparam int PT_DA_BIT = 5;
    localparam int PT_SA_BIT = 6;
    localparam int PERM_BIT = 15;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_STAMP = 8'h00;
    localparam logic [15:0] PURGE_MASK = 16'h80ff;
    localparam logic [15:0] FULL_MASK = 16'hffff;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [2:0] {
        CO_DELETE  = 3'b000,
        CO_ADD     = 3'b001,
        CO_READ    = 3'b010,
        CO_SETADDR = 3'b011,
        CO_PURGE   = 3'b100
    } chk_cam_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUMP = 2'b01,
        ST_CAM  = 2'b10
    } chk_state_t;

    typedef struct packed {
        chk_cam_op_t op;
        logic [47:0] key;
        logic [15:0] data;
        logic [15:0] mask;
    } chk_cam_cmd_t;

    typedef struct packed {
        logic [63:0] entry;
        logic [31:0] status;
    } chk_cam_rsp_t;

endpackage

// *** chk_stamp.sv ***
// Purpose: 8-bit wrapping time stamp counter
// Assumes: one increment request per clock at most
// Notes:   wraps from ff to 00
`timescale 1ns/1ps
`default_nettype none
module chk_stamp
    import chk_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // control
    input  wire logic       inc,
    output logic      [7:0] value
);
    always_ff @(posedge clk) begin
        if (rst) begin
            value <= RST_STAMP;
        end else if (inc) begin
            value <= value + 8'h01;
        end
    end
endmodule
`default_nettype wire

// *** chk_sync.sv ***
// Purpose: two-flop synchroniser for pin inputs
// Assumes: each bit is a quasi-static level or slower than two clocks
// Notes:   only the second stage leaves this module
`timescale 1ns/1ps
`default_nettype none
module chk_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // levels
    input  wire logic [W-1:0] async,
    output logic      [W-1:0] synced
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '1;
            synced <= '1;
        end else begin
            meta_q <= async;
            synced <= meta_q;
        end
    end
endmodule
`default_nettype wire
